// file: hdl/sacc_ctrl.sv
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sacc_ctrl
	import sacc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic conversion_start_request,
	input wire logic comparator_shutdown,
	input wire logic [11:0] sar_sample_code,
	output logic [4:0] mux_channel,
	output logic comparator_enable,
	output logic converter_powered,
	output logic sampling_flag,
	output logic busy_flag,
	output logic result_valid_flag,
	output logic [11:0] conversion_result,
	output logic irq
);

	typedef struct packed
	{
		logic wr_pend;
		logic rd_pend;
		logic [11:0] addr;
		logic [31:0] rdata;
		logic [3:0] mode;
		logic [7:0] sample_time_count;
		logic [4:0] chan;
		logic [7:0] clkdiv;
		logic sw_start;
		logic [7:0] div_cnt;
		logic start_seen;
		logic end_sync;
		sacc_state_t state;
		logic [8:0] phase_cnt;
		logic [1:0] res_lat;
		logic cal_lat;
		logic pwr_keep;
		logic powered;
		logic sampling;
		logic busy;
		logic valid;
		logic [11:0] sar;
		logic [11:0] result;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [2:0] shut_sync;
		logic shut_lvl;
	} sacc_regs_t;

	sacc_regs_t r_reg;
	sacc_regs_t r_next;

	function automatic logic [3:0] sacc_bits(input logic [1:0] res);
		case (res)
			SACC_RES_12: sacc_bits = 4'hc;
			SACC_RES_8: sacc_bits = 4'h8;
			default: sacc_bits = 4'ha;
		endcase
	endfunction : sacc_bits

	function automatic logic [11:0] sacc_justify(input logic [1:0] res,
		input logic [11:0] v);
		case (res)
			SACC_RES_8: sacc_justify = {v[11:4], 4'h0};
			SACC_RES_12: sacc_justify = v;
			default: sacc_justify = {v[11:2], 2'h0};
		endcase
	endfunction : sacc_justify

	logic acc_ok;
	logic conv_tick;
	logic start_req;
	logic conv_done;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	assign acc_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.rdata;
	assign mux_channel = r_reg.chan;
	assign sampling_flag = r_reg.sampling;
	assign busy_flag = r_reg.busy;
	assign result_valid_flag = r_reg.valid;
	assign conversion_result = r_reg.result;
	assign converter_powered = r_reg.powered;
	assign comparator_enable = r_reg.powered && !r_reg.shut_lvl;
	assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

	always_comb
	begin
		r_next = r_reg;
		irq_set = 2'h0;
		irq_clr = 2'h0;
		conv_done = 1'b0;
		r_next.sw_start = 1'b0;
		r_next.rdata = 32'h0;

		// shutdown pin comes from outside: three stages, accept on agreement
		r_next.shut_sync = {r_reg.shut_sync[1:0], comparator_shutdown};
		if (r_reg.shut_sync[2] == r_reg.shut_sync[1])
			r_next.shut_lvl = r_reg.shut_sync[2];

		r_next.wr_pend = acc_ok && hwrite;
		r_next.rd_pend = acc_ok && !hwrite;
		if (acc_ok)
			r_next.addr = haddr[11:0];
		if (acc_ok && !hwrite)
		begin
			case ({haddr[11:2], 2'b00})
				SACC_OFF_MODE: r_next.rdata = {28'h0, r_reg.mode};
				SACC_OFF_STC: r_next.rdata = {24'h0, r_reg.sample_time_count};
				SACC_OFF_CTRL: r_next.rdata = {11'h0, r_reg.chan, r_reg.clkdiv,
					8'h0};
				SACC_OFF_STAT: r_next.rdata = {28'h0, r_reg.powered,
					r_reg.valid, r_reg.busy, r_reg.sampling};
				SACC_OFF_RESULT: r_next.rdata = {20'h0, r_reg.result};
				SACC_OFF_IRQ_STAT: r_next.rdata = {30'h0, r_reg.irq_stat};
				SACC_OFF_IRQ_MASK: r_next.rdata = {30'h0, r_reg.irq_mask};
				default: r_next.rdata = 32'h0;
			endcase
		end
		if (r_reg.wr_pend)
		begin
			case ({r_reg.addr[11:2], 2'b00})
				SACC_OFF_MODE: r_next.mode = hwdata[3:0];
				SACC_OFF_STC: r_next.sample_time_count = hwdata[7:0];
				SACC_OFF_CTRL:
				begin
					r_next.sw_start = hwdata[0];
					r_next.clkdiv = hwdata[15:8];
					r_next.chan = hwdata[20:16];
				end
				SACC_OFF_IRQ_STAT: irq_clr = hwdata[1:0];
				SACC_OFF_IRQ_MASK: r_next.irq_mask = hwdata[1:0];
				default: ;
			endcase
		end

		// conversion clock as an enable pulse from the system clock
		conv_tick = 1'b0;
		if (r_reg.div_cnt >= r_reg.clkdiv)
		begin
			r_next.div_cnt = 8'h00;
			conv_tick = 1'b1;
		end
		else
			r_next.div_cnt = r_reg.div_cnt + 8'h01;

		// one system-clock sync period at start, one at end
		start_req = conversion_start_request || r_reg.sw_start;
		r_next.start_seen = 1'b0;
		if (start_req && !r_reg.busy && !r_reg.start_seen)
		begin
			r_next.start_seen = 1'b1;
			r_next.valid = 1'b0;
			irq_set[SACC_IRQ_START] = 1'b1;
		end

		r_next.end_sync = 1'b0;
		case (r_reg.state)
			SACC_IDLE:
			begin
				if (r_reg.start_seen)
				begin
					r_next.state = SACC_SAMPLE;
					r_next.sampling = 1'b1;
					r_next.busy = 1'b1;
					r_next.powered = 1'b1;
					r_next.res_lat = r_reg.mode[1:0];
					r_next.cal_lat = !r_reg.mode[SACC_CAL_BIT];
					r_next.pwr_keep = r_reg.mode[SACC_PWR_BIT];
					r_next.phase_cnt = SACC_SAMPLE_BASE + {1'b0, r_reg.sample_time_count};
				end
				if (r_reg.end_sync)
				begin
					r_next.busy = 1'b0;
					r_next.valid = 1'b1;
					conv_done = 1'b1;
					if (!r_reg.pwr_keep)
						r_next.powered = 1'b0;
				end
			end
			SACC_SAMPLE:
			begin
				if (conv_tick)
				begin
					r_next.phase_cnt = r_reg.phase_cnt - 9'h001;
					if (r_reg.phase_cnt == 9'h001)
					begin
						r_next.state = SACC_DISTRIB;
						r_next.sampling = 1'b0;
						r_next.sar = sar_sample_code;
						r_next.phase_cnt = {5'h0, sacc_bits(r_reg.res_lat)};
					end
				end
			end
			SACC_DISTRIB:
			begin
				if (conv_tick)
				begin
					r_next.phase_cnt = r_reg.phase_cnt - 9'h001;
					if (r_reg.phase_cnt == 9'h001)
					begin
						r_next.result = sacc_justify(r_reg.res_lat, r_reg.sar);
						if (r_reg.cal_lat)
						begin
							r_next.state = SACC_POSTCAL;
							r_next.phase_cnt = {5'h0, SACC_POSTCAL_CYC};
						end
						else
						begin
							r_next.state = SACC_IDLE;
							r_next.end_sync = 1'b1;
						end
					end
				end
			end
			SACC_POSTCAL:
			begin
				if (conv_tick)
				begin
					r_next.phase_cnt = r_reg.phase_cnt - 9'h001;
					if (r_reg.phase_cnt == 9'h001)
					begin
						r_next.state = SACC_IDLE;
						r_next.end_sync = 1'b1;
					end
				end
			end
			default: r_next.state = SACC_IDLE;
		endcase

		irq_set[SACC_IRQ_DONE] = conv_done;
		r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_set;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r_reg <= '0;
			r_reg.mode <= SACC_MODE_RST;
			r_reg.sample_time_count <= SACC_STC_RST;
			r_reg.chan <= SACC_CHAN_RST;
			r_reg.clkdiv <= SACC_CLKDIV_RST;
			r_reg.state <= SACC_IDLE;
		end
		else
			r_reg <= r_next;
	end

	AST_SAMPLE_TO_DISTRIB: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(sampling_flag) |-> busy_flag)
		else $error("sampling ended without busy");
	AST_VALID_ON_BUSY_FALL: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(busy_flag) |-> result_valid_flag)
		else $error("valid not raised as busy fell");
	AST_START_SETS_BUSY: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.start_seen && r_reg.state == SACC_IDLE) |=> busy_flag
		&& sampling_flag && !result_valid_flag)
		else $error("start did not begin sampling");
	AST_VALID_HOLD: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(result_valid_flag && !start_req) |=> result_valid_flag)
		else $error("valid dropped without start");
	AST_JUST8: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(result_valid_flag) && r_reg.res_lat == SACC_RES_8
		|-> conversion_result == {r_reg.sar[11:4], 4'h0})
		else $error("8-bit result not justified");
	AST_JUST10: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(result_valid_flag) && r_reg.res_lat == SACC_RES_10
		|-> conversion_result == {r_reg.sar[11:2], 2'h0})
		else $error("10-bit result not justified");
	AST_RES12_FULL: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(result_valid_flag) && r_reg.res_lat == SACC_RES_12
		|-> conversion_result == r_reg.sar)
		else $error("12-bit result lost bits");
	AST_POSTCAL_BUSY: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_POSTCAL |-> busy_flag && !sampling_flag)
		else $error("busy low during calibration");
	AST_NOCAL_SKIP: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.state == SACC_DISTRIB && !r_reg.cal_lat)
		|=> r_reg.state != SACC_POSTCAL)
		else $error("calibration run when disabled");
	AST_CAL_ENTERED: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_DISTRIB && r_reg.cal_lat && conv_tick
		&& r_reg.phase_cnt == 9'h001 |=> r_reg.state == SACC_POSTCAL)
		else $error("calibration skipped when enabled");
	AST_NOCAL_END: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_DISTRIB && !r_reg.cal_lat && conv_tick
		&& r_reg.phase_cnt == 9'h001 |=> r_reg.end_sync ##1 !busy_flag)
		else $error("busy not dropped after distribution");
	AST_POSTCAL_END: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_POSTCAL && conv_tick
		&& r_reg.phase_cnt == 9'h001 |=> r_reg.end_sync ##1 !busy_flag)
		else $error("busy not dropped after calibration");
	AST_SAMPLE_FLAGS: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_SAMPLE |-> sampling_flag && busy_flag)
		else $error("flags wrong while sampling");
	AST_DISTRIB_FLAGS: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_DISTRIB |-> busy_flag && !sampling_flag)
		else $error("flags wrong during distribution");
	AST_IDLE_NO_SAMPLE: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.state == SACC_IDLE |-> !sampling_flag)
		else $error("sampling flag high while idle");
	AST_BUSY_IGNORES: assert property (
		@(posedge hclk) disable iff (!hresetn)
		busy_flag |=> !r_reg.start_seen)
		else $error("start taken while busy");
	AST_RESULT_HOLD: assert property (
		@(posedge hclk) disable iff (!hresetn)
		result_valid_flag && !start_req |=> $stable(conversion_result))
		else $error("result changed while valid");
	AST_POWER_DOWN: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(busy_flag) && !r_reg.pwr_keep |-> !converter_powered)
		else $error("converter stayed powered");
	AST_POWER_KEEP: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$fell(busy_flag) && r_reg.pwr_keep |-> converter_powered)
		else $error("converter powered down when kept");
	AST_SHUTDOWN: assert property (
		@(posedge hclk) disable iff (!hresetn)
		r_reg.shut_lvl |-> !comparator_enable)
		else $error("comparators on during shutdown");
	// four samples cover three sync stages plus the agreement register
	AST_SHUTDOWN_PIN: assert property (
		@(posedge hclk) disable iff (!hresetn)
		comparator_shutdown [*4] |=> !comparator_enable)
		else $error("shutdown pin did not stop comparators");

endmodule : sacc_ctrl

`default_nettype wire

// file: hdl/sacc_pkg.sv
package sacc_pkg;

	localparam logic [11:0] SACC_OFF_MODE = 12'h000;
	localparam logic [11:0] SACC_OFF_STC = 12'h004;
	localparam logic [11:0] SACC_OFF_CTRL = 12'h008;
	localparam logic [11:0] SACC_OFF_STAT = 12'h00c;
	localparam logic [11:0] SACC_OFF_RESULT = 12'h010;
	localparam logic [11:0] SACC_OFF_IRQ_STAT = 12'h014;
	localparam logic [11:0] SACC_OFF_IRQ_MASK = 12'h018;

	localparam logic [3:0] SACC_MODE_RST = 4'h0;
	localparam logic [7:0] SACC_STC_RST = 8'h00;
	localparam logic [4:0] SACC_CHAN_RST = 5'h00;
	localparam int SACC_CAL_BIT = 3;
	localparam int SACC_PWR_BIT = 2;

	localparam logic [1:0] SACC_RES_10 = 2'h0;
	localparam logic [1:0] SACC_RES_12 = 2'h1;
	localparam logic [1:0] SACC_RES_8 = 2'h2;

	localparam logic [7:0] SACC_CLKDIV_RST = 8'h03;
	localparam logic [8:0] SACC_SAMPLE_BASE = 9'h002;
	localparam logic [3:0] SACC_POSTCAL_CYC = 4'h2;

	localparam int SACC_IRQ_DONE = 0;
	localparam int SACC_IRQ_START = 1;

	typedef enum logic [3:0]
	{
		SACC_IDLE = 4'b0001,
		SACC_SAMPLE = 4'b0010,
		SACC_DISTRIB = 4'b0100,
		SACC_POSTCAL = 4'b1000
	} sacc_state_t;

endpackage : sacc_pkg

// file: verif/sacc_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_fabric_model
(
	input wire logic hclk,
	input wire logic kick,
	input wire logic shut,
	input wire logic [11:0] code,
	input wire logic busy_flag,
	output logic conversion_start_request,
	output logic comparator_shutdown,
	output logic [11:0] sar_sample_code
);
	logic held, pb;
	initial
	begin
		conversion_start_request = 1'b0;
		comparator_shutdown = 1'b0;
		sar_sample_code = 12'h000;
		held = 1'b0;
		pb = 1'b0;
	end
	// outside a conversion the code keeps toggling so a late capture shows
	always @(posedge hclk)
	begin
		conversion_start_request <= kick;
		comparator_shutdown <= shut;
		if (kick && !held)
		begin
			sar_sample_code <= code;
			held <= 1'b1;
		end
		else if (!held)
			sar_sample_code <= ~sar_sample_code;
		if (pb && busy_flag === 1'b0)
			held <= 1'b0;
		pb <= busy_flag === 1'b1;
	end
endmodule : sacc_fabric_model
`default_nettype wire

// file: verif/sar_adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_tb_top import sacc_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, kick, shut;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [11:0] code, conversion_result, sar_sample_code;
	logic conversion_start_request, comparator_shutdown, comparator_enable;
	logic converter_powered, sampling_flag, busy_flag, result_valid_flag;
	logic [4:0] mux_channel;
	logic [11:0] exp_q[$];
	logic pv, pb, ps;
	int miscompares, tests_run, seed, bcnt, scnt, sexp, bexp;
	sacc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.conversion_start_request(conversion_start_request),
		.comparator_shutdown(comparator_shutdown),
		.sar_sample_code(sar_sample_code), .mux_channel(mux_channel),
		.comparator_enable(comparator_enable),
		.converter_powered(converter_powered),
		.sampling_flag(sampling_flag), .busy_flag(busy_flag),
		.result_valid_flag(result_valid_flag),
		.conversion_result(conversion_result), .irq(irq));
	sacc_fabric_model fab (.hclk(hclk), .kick(kick), .shut(shut),
		.code(code), .busy_flag(busy_flag),
		.conversion_start_request(conversion_start_request),
		.comparator_shutdown(comparator_shutdown),
		.sar_sample_code(sar_sample_code));
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h00000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic conv(input logic [3:0] m, input logic [7:0] s,
		input logic k);
		int n, w;
		logic [11:0] e;
		n = (m[1:0] == SACC_RES_12) ? 12 : (m[1:0] == SACC_RES_8) ? 8 : 10;
		code = 12'($random(seed));
		bus(1'b1, SACC_OFF_MODE, {28'h0, m}, rd);
		bus(1'b1, SACC_OFF_STC, {24'h0, s}, rd);
		bus(1'b1, SACC_OFF_IRQ_MASK, {31'h0, k}, rd);
		sexp = 2 + s;
		bexp = 3 + s + n + (m[3] ? 0 : 2);
		e = code & (n == 12 ? 12'hfff : n == 10 ? 12'hffc : 12'hff0);
		exp_q.push_back(e);
		kick <= 1'b1;
		@(posedge hclk);
		kick <= 1'b0;
		repeat (6) @(posedge hclk);
		// a second start inside the conversion must leave no extra result
		kick <= 1'b1;
		@(posedge hclk);
		kick <= 1'b0;
		w = 0;
		while (result_valid_flag !== 1'b1 && w < 2000)
		begin
			@(posedge hclk);
			w++;
		end
		chk(w < 2000, 1);
		bus(1'b0, SACC_OFF_RESULT, 32'h0, rd);
		chk(rd, {20'h0, e});
		chk(hresp, 0);
		repeat (8) @(posedge hclk);
		chk(result_valid_flag, 1);
		chk(converter_powered, m[2]);
		chk(irq, k);
		bus(1'b1, SACC_OFF_IRQ_MASK, 32'h1, rd);
		repeat (2) @(posedge hclk);
		chk(irq, 1);
		bus(1'b1, SACC_OFF_IRQ_STAT, 32'h3, rd);
		repeat (2) @(posedge hclk);
		chk(irq, 0);
		bus(1'b0, SACC_OFF_MODE, 32'h0, rd);
		chk(rd, {28'h0, m});
		$display("test conversion mode %h stc %0d done", m, s);
	endtask : conv
	always @(posedge hclk)
	begin
		if (!ps && sampling_flag === 1'b1)
			scnt = 0;
		if (!pb && busy_flag === 1'b1)
			bcnt = 0;
		if (sampling_flag === 1'b1)
			scnt++;
		if (busy_flag === 1'b1)
			bcnt++;
		if (ps && sampling_flag === 1'b0)
		begin
			chk(busy_flag, 1);
			chk(scnt >= sexp - 1 && scnt <= sexp + 1, 1);
		end
		if (!pv && result_valid_flag === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(0, 1);
			else
				chk(conversion_result, exp_q.pop_front());
			chk(busy_flag, 0);
			chk(bcnt >= bexp - 1 && bcnt <= bexp + 2, 1);
		end
		ps = sampling_flag === 1'b1;
		pb = busy_flag === 1'b1;
		pv = result_valid_flag === 1'b1;
	end
	initial
	begin
		#(8 * 40000);
		miscompares++;
		test_done;
	end
	initial
	begin
		seed = 58955;
		{hresetn, hsel, hwrite, kick, shut, pv, pb, ps} = 8'h00;
		{haddr, hwdata, htrans, code} = '0;
		{miscompares, tests_run, bcnt, scnt, sexp, bexp} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, SACC_OFF_MODE, 32'h0, rd);
		chk(rd, {28'h0, SACC_MODE_RST});
		bus(1'b0, SACC_OFF_STC, 32'h0, rd);
		chk(rd, {24'h0, SACC_STC_RST});
		bus(1'b1, 12'h020, 32'hffffffff, rd);
		bus(1'b0, 12'h020, 32'h0, rd);
		chk(rd, 32'h0);
		// divider 0 makes one conversion tick per system cycle
		bus(1'b1, SACC_OFF_CTRL, 32'h001f0000, rd);
		@(posedge hclk);
		chk(mux_channel, 5'h1f);
		$display("test registers done");
		for (int i = 0; i < 6; i++)
			conv({1'(i > 2), 1'(i % 2), 2'(i % 3)}, (i == 5) ? 8'hff : 8'(i * 7), i != 1);
		shut <= 1'b1;
		repeat (8) @(posedge hclk);
		chk(comparator_enable, 0);
		conv(4'h5, 8'h03, 1'b1);
		shut <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(comparator_enable, 1);
		$display("test shutdown done");
		test_done;
	end
endmodule : sar_adc_conversion_control_tb_top
`default_nettype wire
